// *** logic/angspi_pkg.sv ***
/*
 * constants shared by both ends of the angle sensor serial link.
 * assumes a 100 MHz system clock on both ends.
 */
package angspi_pkg;
    // frame format
    localparam int FRAME_BITS = 16;
    localparam logic [2:0] CMD_READ = 3'h2;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    // device register addresses
    localparam logic [4:0] REG_ZERO_LO = 5'h00;
    localparam logic [4:0] REG_ZERO_HI = 5'h01;
    localparam logic [4:0] REG_THRESH = 5'h06;
    localparam logic [4:0] REG_DIR = 5'h09;
    localparam logic [4:0] REG_FLAGS = 5'h1B;
    // device register reset values
    localparam logic [7:0] RST_ZERO_LO = 8'h00;
    localparam logic [7:0] RST_ZERO_HI = 8'h00;
    localparam logic [7:0] RST_THRESH = 8'h1C;
    localparam logic [7:0] RST_DIR = 8'h00;
    // field positions
    localparam int THR_LOW_MSB = 7;
    localparam int THR_LOW_LSB = 5;
    localparam int THR_HIGH_MSB = 4;
    localparam int THR_HIGH_LSB = 2;
    localparam int DIR_BIT = 7;
    // field strength levels for the 3 bit threshold codes
    localparam logic [7:0] FIELD_LOW_BASE = 8'h10;
    localparam logic [7:0] FIELD_HIGH_BASE = 8'h40;
    localparam int FIELD_STEP_SH = 3;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int SAMPLE_RATE_HZ = 1_000_000;
    localparam int SAMPLE_DIV = SYS_CLK_HZ / SAMPLE_RATE_HZ;
    localparam int ANGLE_GAP_NS = 150;
    localparam int REG_GAP_NS = 750;
    localparam int ANGLE_GAP_CYC = (ANGLE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REG_GAP_CYC = (REG_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NVM_WAIT_MS = 20;
    localparam int NVM_WAIT_CYC = NVM_WAIT_MS * (SYS_CLK_HZ / 1000);
    // filter: tau = 0.38 / 90 Hz, in microseconds
    localparam int FILTER_CUTOFF_HZ = 90;
    localparam int FILTER_TAU_US = 380_000 / FILTER_CUTOFF_HZ;
    localparam int FILTER_POS_SH = $clog2(FILTER_TAU_US) - 1;
    localparam int FILTER_VEL_SH = 2 * FILTER_POS_SH + 2;
    // pwm: 256 steps of 8 clocks, about 48.8 kHz
    localparam int PWM_PRESCALE = 8;
    // host command registers on apb
    localparam logic [7:0] HREG_CTRL = 8'h00;
    localparam logic [7:0] HREG_STATUS = 8'h04;
    localparam logic [7:0] HREG_RESULT = 8'h08;
    localparam int CTRL_START_BIT = 31;
    localparam int STAT_DONE_BIT = 1;
    // host operations
    typedef enum logic [1:0] {
        OP_ANGLE = 2'h0,
        OP_READ = 2'h1,
        OP_WRITE = 2'h2
    } angspi_op_type;
endpackage

// *** logic/angspi_if.sv ***
/*
 * serial link between the host controller and the angle sensor.
 * assumes the bench drives nothing; data out resolves to low when released.
 */
`timescale 1ns/100ps
`default_nettype none
interface angspi_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    wire miso;
    // released data out is held low by the pull-down
    assign miso = miso_oe ? miso_o : 1'b0;
    modport dev (input sclk, input cs_n, input mosi, output miso_o, output miso_oe);
    modport host (output sclk, output cs_n, output mosi, input miso);
endinterface
`default_nettype wire

// *** logic/angspi_sync.sv ***
/*
 * two flip-flop synchroniser for a bundle of levels.
 * assumes inputs come from outside the clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module angspi_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;
    // first stage read only by the second
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= INIT;
            q_out <= INIT;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** logic/angspi_dev.sv ***
/*
 * angle sensor end: serial slave, register set with slow commit,
 * angle filter, zero and direction, field flags and pwm output.
 * assumes the front-end angle and field words are on SYS_CLK_IN.
 */
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - modes 0 and 3 accepted without setup
// - sample on rise, shift on fall, msb first
// - select low active, idles high
// - host clock at most 25 MHz
// - host commands are 16 bit frames
// - 150 ns idle between angle frames
// - 750 ns idle around register readout
// - 20 ms wait after a write
// - data out driven only while selected
// - low flag when field below low threshold
// - high flag when field above high threshold
// - new front-end angle every microsecond
// - filter time constant 0.38 over cutoff
// - filter adds no lag at constant speed
// - direction and zero are programmable
// - angle read, register read, register write
// - read request 010 plus address
// - write request 100, address, value
// - full angle needs 16 clocks
module angspi_dev
    import angspi_pkg::*;
#(
    parameter int NVM_WAIT = NVM_WAIT_CYC
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    angspi_if.dev LINK,
    input wire logic [15:0] RAW_ANGLE_IN,
    input wire logic [7:0] FIELD_IN,
    output logic PWM_OUT,
    output logic FIELD_LOW_FLAG_OUT,
    output logic FIELD_HIGH_FLAG_OUT
);
    ////////////////////////////////////////////////////////////////////////
    logic s_sclk, s_cs_n, s_mosi;
    logic sclk_prev_q, sel_prev_q;
    logic rise, fall, sel, sel_start;
    logic [4:0] bit_cnt_q;
    logic [15:0] rx_q, tx_q, word;
    logic miso_q, miso_oe_q;
    logic rsp_reg_q;
    logic [4:0] rsp_addr_q;
    logic [7:0] zero_lo_q, zero_hi_q, thresh_q, dir_q;
    logic nvm_busy_q;
    logic [31:0] nvm_cnt_q;
    logic [4:0] nvm_addr_q;
    logic [7:0] nvm_data_q;
    logic [7:0] reg_rd;
    logic [6:0] tick_cnt_q;
    logic tick;
    logic signed [31:0] est_q, vel_q, err32;
    logic [15:0] err;
    logic [15:0] angle_q;
    logic low_q, high_q;
    logic [7:0] low_level, high_level;
    logic [2:0] pre_q;
    logic [7:0] pwm_cnt_q, duty_q;
    logic pwm_q;

    // link pins sampled into the system clock
    angspi_sync #(.WIDTH(3), .INIT(3'h2)) u_sync (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .d_in({LINK.sclk, LINK.cs_n, LINK.mosi}),
        .q_out({s_sclk, s_cs_n, s_mosi})
    );

    // edge and select detection
    assign sel = ~s_cs_n;
    assign sel_start = sel & ~sel_prev_q;
    assign rise = sel & s_sclk & ~sclk_prev_q;
    assign fall = sel & ~s_sclk & sclk_prev_q;
    assign word = {rx_q[14:0], s_mosi};
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sclk_prev_q <= 1'b0;
            sel_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= s_sclk;
            sel_prev_q <= sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit counter and receive shifter; only the counter is cleared while deselected
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            bit_cnt_q <= 5'h00;
            rx_q <= 16'h0000;
        end else if (!sel) begin
            bit_cnt_q <= 5'h00;
        end else if (rise && bit_cnt_q < 5'(FRAME_BITS)) begin
            rx_q <= word;
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // transmit: msb on select, next bit on each fall after a rise
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tx_q <= 16'h0000;
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
        end else if (!sel) begin
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
        end else if (sel_start) begin
            tx_q <= rsp_reg_q ? {reg_rd, 8'h00} : angle_q;
            miso_q <= rsp_reg_q ? reg_rd[7] : angle_q[15];
            miso_oe_q <= 1'b1;
        end else if (fall && bit_cnt_q != 5'h00) begin
            // mode 3 opens with a fall before any rise, which is skipped
            tx_q <= {tx_q[14:0], 1'b0};
            miso_q <= tx_q[14];
        end
    end
    assign LINK.miso_o = miso_q;
    assign LINK.miso_oe = miso_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // frame decode on the sixteenth rise; short frames change nothing
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rsp_reg_q <= 1'b0;
            rsp_addr_q <= 5'h00;
        end else if (rise && bit_cnt_q == 5'(FRAME_BITS - 1)) begin
            rsp_addr_q <= word[12:8];
            // read or write request answers with the register next frame
            rsp_reg_q <= (word[15:13] == CMD_READ) || (word[15:13] == CMD_WRITE);
        end
    end

    // slow commit of a written value; a write while busy is ignored
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            nvm_busy_q <= 1'b0;
            nvm_cnt_q <= 32'h0000_0000;
            nvm_addr_q <= 5'h00;
            nvm_data_q <= 8'h00;
        end else if (rise && bit_cnt_q == 5'(FRAME_BITS - 1) && !nvm_busy_q
                     && word[15:13] == CMD_WRITE) begin
            nvm_busy_q <= 1'b1;
            nvm_cnt_q <= 32'(NVM_WAIT - 1);
            nvm_addr_q <= word[12:8];
            nvm_data_q <= word[7:0];
        end else if (nvm_busy_q) begin
            nvm_cnt_q <= nvm_cnt_q - 32'h0000_0001;
            if (nvm_cnt_q == 32'h0000_0000) begin
                nvm_busy_q <= 1'b0;
            end
        end
    end

    // configuration registers; readback shows the old value until commit
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            zero_lo_q <= RST_ZERO_LO;
            zero_hi_q <= RST_ZERO_HI;
            thresh_q <= RST_THRESH;
            dir_q <= RST_DIR;
        end else if (nvm_busy_q && nvm_cnt_q == 32'h0000_0000) begin
            unique case (nvm_addr_q)
                REG_ZERO_LO: zero_lo_q <= nvm_data_q;
                REG_ZERO_HI: zero_hi_q <= nvm_data_q;
                REG_THRESH: thresh_q <= nvm_data_q & 8'hFC;
                REG_DIR: dir_q <= nvm_data_q & 8'h80;
                default: zero_lo_q <= zero_lo_q;
            endcase
        end
    end

    // register readout mux, unmapped reads as zero
    always_comb begin
        unique case (rsp_addr_q)
            REG_ZERO_LO: reg_rd = zero_lo_q;
            REG_ZERO_HI: reg_rd = zero_hi_q;
            REG_THRESH: reg_rd = thresh_q;
            REG_DIR: reg_rd = dir_q;
            REG_FLAGS: reg_rd = {high_q, low_q, 6'h00};
            default: reg_rd = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // front-end sample tick at 1 MHz
    assign tick = (tick_cnt_q == 7'(SAMPLE_DIV - 1));
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tick_cnt_q <= 7'h00;
        end else begin
            tick_cnt_q <= tick ? 7'h00 : tick_cnt_q + 7'h01;
        end
    end

    // second order tracking filter: velocity term removes ramp lag
    assign err = RAW_ANGLE_IN - est_q[31:16];
    assign err32 = {err, 16'h0000};
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            est_q <= 32'sh0000_0000;
            vel_q <= 32'sh0000_0000;
        end else if (tick) begin
            est_q <= est_q + vel_q + (err32 >>> FILTER_POS_SH);
            vel_q <= vel_q + (err32 >>> FILTER_VEL_SH);
        end
    end

    // direction then zero offset: out = dir(angle) + zero word
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            angle_q <= 16'h0000;
        end else begin
            angle_q <= (dir_q[DIR_BIT] ? 16'h0000 - est_q[31:16] : est_q[31:16])
                       + {zero_hi_q, zero_lo_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field threshold compare
    assign low_level = FIELD_LOW_BASE
                       + (8'({thresh_q[THR_LOW_MSB:THR_LOW_LSB], 3'h0}) << FIELD_STEP_SH);
    assign high_level = FIELD_HIGH_BASE
                        + (8'({thresh_q[THR_HIGH_MSB:THR_HIGH_LSB], 3'h0}) << FIELD_STEP_SH);
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            low_q <= 1'b0;
            high_q <= 1'b0;
        end else begin
            low_q <= FIELD_IN < low_level;
            high_q <= FIELD_IN > high_level;
        end
    end
    assign FIELD_LOW_FLAG_OUT = low_q;
    assign FIELD_HIGH_FLAG_OUT = high_q;

    // free running pwm, duty taken at each period start
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pre_q <= 3'h0;
            pwm_cnt_q <= 8'h00;
            duty_q <= 8'h00;
            pwm_q <= 1'b0;
        end else begin
            pre_q <= (pre_q == 3'(PWM_PRESCALE - 1)) ? 3'h0 : pre_q + 3'h1;
            if (pre_q == 3'(PWM_PRESCALE - 1)) begin
                pwm_cnt_q <= pwm_cnt_q + 8'h01;
                if (pwm_cnt_q == 8'hFF) begin
                    duty_q <= angle_q[15:8];
                end
            end
            pwm_q <= pwm_cnt_q < duty_q;
        end
    end
    assign PWM_OUT = pwm_q;
endmodule
`default_nettype wire

// *** logic/angspi_host.sv ***
/*
 * host controller: apb command registers and the serial master.
 * assumes an apb master on SYS_CLK_IN; sensor data out arrives asynchronously.
 */
`timescale 1ns/100ps
`default_nettype none
module angspi_host
    import angspi_pkg::*;
#(
    parameter int NVM_WAIT = NVM_WAIT_CYC,
    parameter int SCLK_HALF = 8,
    parameter bit CPOL = 1'b0
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    angspi_if.host LINK,
    input wire logic APB_PSEL_IN,
    input wire logic APB_PENABLE_IN,
    input wire logic APB_PWRITE_IN,
    input wire logic [7:0] APB_PADDR_IN,
    input wire logic [31:0] APB_PWDATA_IN,
    output logic [31:0] APB_PRDATA_OUT,
    output logic APB_PREADY_OUT,
    output logic APB_PSLVERR_OUT
);
    typedef enum logic [2:0] {
        H_IDLE = 3'h0, H_WAIT = 3'h1, H_LEAD = 3'h2, H_SHIFT = 3'h3, H_TAIL = 3'h4
    } angspi_hstate_type;
    angspi_hstate_type st_q;
    logic s_miso;
    logic [31:0] ctrl_q, tmr_q, gap_q;
    logic [15:0] tx_q, rx_q, result_q;
    logic [5:0] tog_q;
    logic [4:0] samp_q;
    logic second_q, last_reg_q, done_q, access, start;
    logic sclk_q, cs_n_q, mosi_q;
    logic [31:0] need;

    angspi_sync #(.WIDTH(1), .INIT(1'b0)) u_sync (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .d_in(LINK.miso),
        .q_out(s_miso)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb slave with one wait state
    assign access = APB_PSEL_IN & APB_PENABLE_IN & ~APB_PREADY_OUT;
    assign start = access & APB_PWRITE_IN & (APB_PADDR_IN == HREG_CTRL)
                   & APB_PWDATA_IN[CTRL_START_BIT] & (st_q == H_IDLE);
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            APB_PREADY_OUT <= 1'b0;
            APB_PSLVERR_OUT <= 1'b0;
            APB_PRDATA_OUT <= 32'h0000_0000;
            ctrl_q <= 32'h0000_0000;
        end else begin
            APB_PREADY_OUT <= access;
            APB_PSLVERR_OUT <= access && APB_PADDR_IN != HREG_CTRL
                               && APB_PADDR_IN != HREG_STATUS && APB_PADDR_IN != HREG_RESULT;
            APB_PRDATA_OUT <= 32'h0000_0000;
            if (access && !APB_PWRITE_IN) begin
                unique case (APB_PADDR_IN)
                    HREG_CTRL: APB_PRDATA_OUT <= {1'b0, ctrl_q[30:0]};
                    HREG_STATUS: APB_PRDATA_OUT <= {30'h0, done_q, st_q != H_IDLE};
                    HREG_RESULT: APB_PRDATA_OUT <= {16'h0000, result_q};
                    default: APB_PRDATA_OUT <= 32'h0000_0000;
                endcase
            end
            if (start) begin
                ctrl_q <= APB_PWDATA_IN; // [1:0] op, [12:8] addr, [23:16] data
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // idle time needed before the next frame
    always_comb begin
        need = 32'(ANGLE_GAP_CYC);
        if (second_q && ctrl_q[1:0] == OP_WRITE) begin
            need = 32'(NVM_WAIT);
        end else if (last_reg_q || ctrl_q[1:0] != OP_ANGLE) begin
            need = 32'(REG_GAP_CYC);
        end
    end

    // serial master sequence
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st_q <= H_IDLE;
            tmr_q <= 32'h0000_0000;
            gap_q <= 32'(REG_GAP_CYC);
            tx_q <= 16'h0000;
            rx_q <= 16'h0000;
            tog_q <= 6'h00;
            samp_q <= 5'h00;
            second_q <= 1'b0;
            last_reg_q <= 1'b0;
            done_q <= 1'b0;
            result_q <= 16'h0000;
            sclk_q <= CPOL;
            cs_n_q <= 1'b1;
            mosi_q <= 1'b0;
        end else begin
            if (gap_q != 32'hFFFF_FFFF && cs_n_q) begin
                gap_q <= gap_q + 32'h0000_0001;
            end
            unique case (st_q)
                H_IDLE: begin
                    if (start) begin
                        st_q <= H_WAIT;
                        done_q <= 1'b0;
                        second_q <= 1'b0;
                        tx_q <= (APB_PWDATA_IN[1:0] == OP_READ) ? {CMD_READ, APB_PWDATA_IN[12:8], 8'h00}
                              : (APB_PWDATA_IN[1:0] == OP_WRITE)
                              ? {CMD_WRITE, APB_PWDATA_IN[12:8], APB_PWDATA_IN[23:16]} : 16'h0000;
                    end else if (access && APB_PWRITE_IN && APB_PADDR_IN == HREG_STATUS
                                 && APB_PWDATA_IN[STAT_DONE_BIT]) begin
                        done_q <= 1'b0;
                    end
                end
                H_WAIT: begin
                    if (gap_q >= need) begin
                        st_q <= H_LEAD;
                        cs_n_q <= 1'b0;
                        mosi_q <= tx_q[15];
                        tmr_q <= 32'(SCLK_HALF - 1);
                        tog_q <= 6'h00;
                        samp_q <= 5'h00;
                    end
                end
                H_LEAD, H_SHIFT: begin
                    tmr_q <= tmr_q - 32'h0000_0001;
                    if (tmr_q == 32'h0000_0000) begin
                        tmr_q <= 32'(SCLK_HALF - 1);
                        st_q <= H_SHIFT;
                        if (tog_q == 6'(2 * FRAME_BITS)) begin
                            st_q <= H_TAIL;
                        end else begin
                            sclk_q <= ~sclk_q;
                            tog_q <= tog_q + 6'h01;
                            if (!sclk_q) begin
                                rx_q <= {rx_q[14:0], s_miso};
                                samp_q <= samp_q + 5'h01;
                            end else if (samp_q != 5'h00) begin
                                tx_q <= {tx_q[14:0], 1'b0};
                                mosi_q <= tx_q[14];
                            end
                        end
                    end
                end
                H_TAIL: begin
                    cs_n_q <= 1'b1;
                    gap_q <= 32'h0000_0000;
                    last_reg_q <= ctrl_q[1:0] != OP_ANGLE;
                    if (ctrl_q[1:0] != OP_ANGLE && !second_q) begin
                        second_q <= 1'b1;
                        tx_q <= 16'h0000;
                        st_q <= H_WAIT;
                    end else begin
                        result_q <= (ctrl_q[1:0] == OP_ANGLE) ? rx_q : {8'h00, rx_q[15:8]};
                        done_q <= 1'b1;
                        st_q <= H_IDLE;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
    assign LINK.sclk = sclk_q;
    assign LINK.cs_n = cs_n_q;
    assign LINK.mosi = mosi_q;
endmodule
`default_nettype wire

// *** dv/angspi_monitor.sv ***
/* link checks for the angle sensor serial pair.
   assumes a mode 0 host and the angspi_if signals as inputs. */
`timescale 1ns/100ps
`default_nettype none
module angspi_monitor (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic miso
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);
    logic sclk_q;
    logic [4:0] rise_q;
    logic [7:0] gap_q;
    // clock rises seen in the current frame
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sclk_q <= 1'b0;
            rise_q <= 5'h00;
        end else begin
            sclk_q <= sclk;
            rise_q <= cs_n ? 5'h00 : rise_q + 5'(sclk & ~sclk_q);
        end
    end
    // idle cycles before a frame, saturating
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            gap_q <= 8'hFF; // no frame yet, so no gap is owed
        end else begin
            gap_q <= !cs_n ? 8'h00 : gap_q + 8'(gap_q != 8'hFF);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_frame_len: assert property ($rose(cs_n) |-> rise_q == 5'h10)
        else $error("frame without sixteen clock rises");
    a_frame_gap: assert property ($fell(cs_n) |-> gap_q >= 8'h0F)
        else $error("idle gap too short");
    a_idle_clock: assert property (cs_n [*2] |-> !sclk)
        else $error("clock not idle low");
    a_mosi_on_fall: assert property ($changed(mosi) && !cs_n && !$fell(cs_n) |-> $fell(sclk))
        else $error("data in moved off a falling edge");
    a_miso_steady: assert property ((sclk && miso_oe) [*5] |-> $stable(miso_o))
        else $error("data out moved while clock high");
    a_select_drives: assert property ($fell(cs_n) |-> ##[2:6] miso_oe)
        else $error("data out not driven after select");
    a_deselect_release: assert property ($rose(cs_n) |-> ##[1:6] !miso_oe)
        else $error("data out not released");
    a_idle_quiet: assert property (cs_n [*6] |-> !miso_oe)
        else $error("data out driven while idle");
    a_released_low: assert property (!miso_oe |-> !miso)
        else $error("released data out not low");
endmodule
`default_nettype wire

// *** dv/angspi_tb_top.sv ***
/* bench for host and sensor ends joined by angspi_if.
   assumes apb orders to the host and a small commit wait. */
`timescale 1ns/100ps
`default_nettype none
module angspi_tb_top
    import angspi_pkg::*;
;
    logic clk, rst, psel, pen, pwr, pready, perr, pwm, flo, fhi, e;
    logic [7:0] paddr, field, lv, hv;
    logic [31:0] pwdata, prdata, prdata3, res;
    logic [7:0] fv [3] = '{8'h30, 8'h90, 8'h60};
    int fail_count, tests_run, pc;
    angspi_if u_angspi_if ();
    angspi_host #(.NVM_WAIT(200)) u_angspi_host (.SYS_CLK_IN(clk), .RST_IN(rst),
        .LINK(u_angspi_if.host), .APB_PSEL_IN(psel), .APB_PENABLE_IN(pen),
        .APB_PWRITE_IN(pwr), .APB_PADDR_IN(paddr), .APB_PWDATA_IN(pwdata),
        .APB_PRDATA_OUT(prdata), .APB_PREADY_OUT(pready), .APB_PSLVERR_OUT(perr));
    angspi_dev #(.NVM_WAIT(200)) u_angspi_dev (.SYS_CLK_IN(clk), .RST_IN(rst),
        .LINK(u_angspi_if.dev), .RAW_ANGLE_IN(16'h0000), .FIELD_IN(field),
        .PWM_OUT(pwm), .FIELD_LOW_FLAG_OUT(flo), .FIELD_HIGH_FLAG_OUT(fhi));
    // mode 3 pair on the same apb orders; its read data must match mode 0
    angspi_if u_angspi_if_m3 ();
    angspi_host #(.NVM_WAIT(200), .CPOL(1'b1)) u_angspi_host_m3 (.SYS_CLK_IN(clk),
        .RST_IN(rst), .LINK(u_angspi_if_m3.host), .APB_PSEL_IN(psel), .APB_PENABLE_IN(pen),
        .APB_PWRITE_IN(pwr), .APB_PADDR_IN(paddr), .APB_PWDATA_IN(pwdata),
        .APB_PRDATA_OUT(prdata3), .APB_PREADY_OUT(), .APB_PSLVERR_OUT());
    angspi_dev #(.NVM_WAIT(200)) u_angspi_dev_m3 (.SYS_CLK_IN(clk), .RST_IN(rst),
        .LINK(u_angspi_if_m3.dev), .RAW_ANGLE_IN(16'h0000), .FIELD_IN(field),
        .PWM_OUT(), .FIELD_LOW_FLAG_OUT(), .FIELD_HIGH_FLAG_OUT());
    angspi_monitor u_angspi_monitor (.SYS_CLK_IN(clk), .RST_IN(rst),
        .sclk(u_angspi_if.sclk), .cs_n(u_angspi_if.cs_n), .mosi(u_angspi_if.mosi),
        .miso_o(u_angspi_if.miso_o), .miso_oe(u_angspi_if.miso_oe), .miso(u_angspi_if.miso));
    ////////////////////////////////////////////////////////////////////////
    // compare and count
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, x, g);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic er);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        er = perr;
        chk("mode 3 data", r, prdata3);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // start a link operation, wait for done, fetch the result
    task op(input logic [1:0] o, input logic [4:0] a, input logic [7:0] v,
        output logic [31:0] r);
        apb(1'b1, HREG_CTRL, {1'b1, 7'h00, v, 3'h0, a, 6'h00, o}, r, e);
        do begin
            apb(1'b0, HREG_STATUS, 32'h0, r, e);
        end while (r[STAT_DONE_BIT] !== 1'b1);
        apb(1'b0, HREG_RESULT, 32'h0, r, e);
    endtask
    task end_sim;
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // free running system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard
    initial begin
        #800000;
        fail_count++;
        end_sim;
    end
    // main sequence
    initial begin
        rst = 1'b1;
        {psel, pen, pwr, paddr, pwdata} = '0;
        field = 8'h60;
        fail_count = 0;
        tests_run = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        op(OP_READ, REG_THRESH, 8'h00, res);
        chk("thresh", {24'h0, RST_THRESH}, {24'h0, res[7:0]});
        op(OP_READ, REG_DIR, 8'h00, res);
        chk("dir", {24'h0, RST_DIR}, {24'h0, res[7:0]});
        op(OP_ANGLE, 5'h00, 8'h00, res);
        chk("angle", 32'h0, {16'h0, res[15:0]});
        op(OP_WRITE, REG_ZERO_LO, 8'h34, res);
        chk("ack", 32'h34, {24'h0, res[7:0]});
        op(OP_WRITE, REG_ZERO_HI, 8'h12, res);
        op(OP_READ, REG_ZERO_HI, 8'h00, res);
        chk("zero hi", 32'h12, {24'h0, res[7:0]});
        op(OP_ANGLE, 5'h00, 8'h00, res);
        chk("offset angle", 32'h1234, {16'h0, res[15:0]});
        op(OP_WRITE, REG_THRESH, 8'h24, res);
        lv = FIELD_LOW_BASE + 8'h40;
        hv = FIELD_HIGH_BASE + 8'h40;
        for (int i = 0; i < 3; i++) begin
            field <= fv[i];
            repeat (8) @(posedge clk);
            chk("low flag", 32'(fv[i] < lv), {31'h0, flo});
            chk("high flag", 32'(fv[i] > hv), {31'h0, fhi});
            op(OP_READ, REG_FLAGS, 8'h00, res);
            chk("flag reg", {24'h0, fv[i] > hv, fv[i] < lv, 6'h00}, {24'h0, res[7:0]});
        end
        // high cycles over one whole pwm period with angle 0x1234 in place
        pc = 0;
        repeat (256 * PWM_PRESCALE) begin
            @(posedge clk);
            pc += pwm;
        end
        chk("pwm duty", 32'(8'h12 * PWM_PRESCALE), pc);
        apb(1'b0, 8'h0C, 32'h0, res, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, res);
        end_sim;
    end
endmodule
`default_nettype wire
